// ### rtl/l2_cache_lock_and_invalidate.sv
// Second-level cache control register, lock policy and global invalidation
module l2_cache_lock_and_invalidate
  import l2_lock_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control register access
  input  wire logic             ctrlWrite,
  input  wire logic [31:0]      ctrlWrData,
  output logic [31:0]           ctrlRdData,
  // Request from core, first-level caches and snoop side
  input  wire logic             reqValid,
  input  wire logic [3:0]       reqKind,
  input  wire logic [SET_W-1:0] reqSet,
  input  wire logic [TAG_W-1:0] reqTag,
  input  wire logic             reqFromInstr,
  input  wire logic             reqInhibited,
  input  wire logic             reqWriteThru,
  input  wire logic             reqL1Hit,
  // Result of the request
  output logic                  respValid,
  output logic                  respHit,
  output logic [1:0]            respHitWay,
  output logic                  respToBus,
  output logic                  respToL1,
  output logic                  respArrayWrite,
  output logic                  respWriteWay,
  output logic                  respBypass,
  // Configuration and error outputs
  output logic                  cacheEnabled,
  output logic [1:0]            wayLockField,
  output logic                  machineCheck
);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic       enable_reg;
  logic       dataOnly_reg;
  logic       globalInv_reg;
  logic [1:0] lock_reg;
  logic       errEnable_reg;
  logic       snoopErr_reg;
  logic       invBusy;
  logic       seqStart;
  logic       lockedSnoopHit;

  // Untracked writable bits keep their value so software reads back what it wrote
  logic [31:0] other_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_reg    <= CTRL_RESET[BIT_ENABLE];      // RQ5
      dataOnly_reg  <= CTRL_RESET[BIT_DATA_ONLY];
      globalInv_reg <= CTRL_RESET[BIT_GLOBAL_INV];
      lock_reg      <= 2'h0;
      errEnable_reg <= CTRL_RESET[BIT_SNOOP_ERREN];
      other_reg     <= CTRL_RESET;
    end else if (ctrlWrite) begin
      enable_reg    <= ctrlWrData[BIT_ENABLE];      // RQ23
      dataOnly_reg  <= ctrlWrData[BIT_DATA_ONLY];
      globalInv_reg <= ctrlWrData[BIT_GLOBAL_INV];
      lock_reg      <= {ctrlWrData[BIT_LOCK_WAY0], ctrlWrData[BIT_LOCK_WAY1]}; // RQ1
      errEnable_reg <= ctrlWrData[BIT_SNOOP_ERREN];
      other_reg     <= ctrlWrData & ~CTRL_STORED_MASK & 32'h7FFF_F0FE;
    end
  end

  // Sticky error: a locked-line snoop hit in the same cycle as a write wins
  always_ff @(posedge clk) begin
    if (reset) begin
      snoopErr_reg <= 1'b0;
    end else if (lockedSnoopHit) begin
      snoopErr_reg <= 1'b1;                         // RQ3
    end else if (ctrlWrite) begin
      snoopErr_reg <= snoopErr_reg & ctrlWrData[BIT_SNOOP_ERR]; // RQ3
    end
  end

  always_comb begin
    ctrlRdData                  = other_reg;
    ctrlRdData[BIT_ENABLE]      = enable_reg;
    ctrlRdData[BIT_DATA_ONLY]   = dataOnly_reg;
    ctrlRdData[BIT_GLOBAL_INV]  = globalInv_reg;
    ctrlRdData[BIT_LOCK_WAY0]   = lock_reg[1];
    ctrlRdData[BIT_LOCK_WAY1]   = lock_reg[0];
    ctrlRdData[BIT_SNOOP_ERREN] = errEnable_reg;
    ctrlRdData[BIT_SNOOP_ERR]   = snoopErr_reg;
    ctrlRdData[BIT_INV_BUSY]    = invBusy;          // RQ4
  end

  // ---------------------------------------------------------------
  // Global invalidation
  // ---------------------------------------------------------------
  // Start on the rising write of the invalidate bit; a bit left set
  // after a run does not restart it, software must clear it first.
  assign seqStart = ctrlWrite && ctrlWrData[BIT_GLOBAL_INV] && !globalInv_reg
                    && !invBusy;                    // RQ25

  logic             clrValid;
  logic [SET_W-1:0] clrSet;

  l2_inv_sequencer u_seq (
    .clk      (clk),
    .reset    (reset),
    .start    (seqStart),
    .busy     (invBusy),
    .clrValid (clrValid),
    .clrSet   (clrSet)
  );                                                // RQ7

  // ---------------------------------------------------------------
  // Lookup
  // ---------------------------------------------------------------
  logic [1:0] hitWay;
  logic       lruWay;
  logic       lockW0;
  logic       lockW1;
  logic       anyHit;
  logic       hitLocked;
  logic       hitWayIdx;

  assign lockW0    = lock_reg[1];
  assign lockW1    = lock_reg[0];
  assign anyHit    = |hitWay;
  assign hitWayIdx = hitWay[1];
  assign hitLocked = (hitWay[0] && lockW0) || (hitWay[1] && lockW1);

  // Array update decision
  logic             wrEn;
  logic             wrWay;
  logic             wrValid;
  logic             lruEn;
  logic             lruVal;
  logic             toBus;
  logic             toL1;
  logic             bypass;
  logic             active;
  logic             allocWay;
  logic             canAlloc;

  // Replacement target: locked ways are never chosen
  always_comb begin
    case (lock_reg)
      LOCK_WAY1: allocWay = 1'b0;                   // RQ14
      LOCK_WAY0: allocWay = 1'b1;                   // RQ14
      default:   allocWay = lruWay;                 // RQ11
    endcase
    canAlloc = (lock_reg != LOCK_BOTH);             // RQ12
  end

  // Only the snoop side is serviced while disabled; nothing is serviced while invalidating
  always_comb begin
    active = reqValid && !invBusy &&
             (enable_reg || (req_kind_e'(reqKind) == REQ_SNOOP));
    bypass = reqValid && !active;                   // RQ5
    if (reqFromInstr && dataOnly_reg) begin
      bypass = reqValid;                            // RQ24
      active = 1'b0;
    end
  end

  always_comb begin
    wrEn    = 1'b0;
    wrWay   = hitWayIdx;
    wrValid = 1'b1;
    lruEn   = 1'b0;
    lruVal  = 1'b0;
    toBus   = bypass;
    toL1    = 1'b0;
    lockedSnoopHit = 1'b0;
    if (active) begin
      case (req_kind_e'(reqKind))
        REQ_READ: begin
          toL1   = anyHit;
          toBus  = !anyHit;
          lruEn  = anyHit;
          lruVal = !hitWayIdx;
        end
        REQ_RELOAD: begin
          toL1 = 1'b1;
          if (anyHit) begin
            lruEn  = 1'b1;
            lruVal = !hitWayIdx;
          end else begin
            toBus = 1'b1;
            wrEn  = canAlloc;                       // RQ15
            wrWay = allocWay;
            lruEn = canAlloc;
            lruVal = !allocWay;
          end
        end
        REQ_CASTOUT: begin
          if (anyHit) begin
            wrEn = 1'b1;
          end else begin
            wrEn  = canAlloc;                       // RQ14
            wrWay = allocWay;
            toBus = !canAlloc;                      // RQ15
          end
        end
        REQ_STORE_WT: begin
          wrEn  = anyHit;                           // RQ16
          toBus = 1'b1;                             // RQ16
        end
        REQ_STCX: begin
          if (anyHit && (reqInhibited || reqWriteThru)) begin
            wrEn    = 1'b1;                         // RQ17
            wrValid = 1'b0;
          end
          toBus = !anyHit || reqInhibited || reqWriteThru;
        end
        REQ_FLUSH: begin
          if (anyHit && hitLocked) begin
            wrEn = reqL1Hit;                        // RQ18
          end else if (anyHit) begin
            wrEn    = 1'b1;
            wrValid = 1'b0;
            toBus   = 1'b1;
          end else begin
            toBus = 1'b1;
          end
        end
        REQ_ZERO: begin
          toBus = !anyHit;                          // RQ19
        end
        REQ_INVBLK: begin
          wrEn    = anyHit;                         // RQ20
          wrValid = 1'b0;
        end
        REQ_SNOOP: begin
          wrEn    = anyHit;                         // RQ13
          wrValid = 1'b0;
          lockedSnoopHit = anyHit && hitLocked;     // RQ3
        end
        default: begin
          toBus = 1'b1;
        end
      endcase
    end
  end

  l2_tag_array u_tags (
    .clk     (clk),
    .rdSet   (reqSet),
    .rdTag   (reqTag),
    .hitWay  (hitWay),
    .lruWay  (lruWay),
    .wrEn    (wrEn),
    .wrSet   (reqSet),
    .wrWay   (wrWay),
    .wrTag   (reqTag),
    .wrValid (wrValid),
    .lruEn   (lruEn),
    .lruVal  (lruVal),
    .clrEn   (clrValid),
    .clrSet  (clrSet)
  );

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      respValid      <= 1'b0;
      respHit        <= 1'b0;
      respHitWay     <= 2'h0;
      respToBus      <= 1'b0;
      respToL1       <= 1'b0;
      respArrayWrite <= 1'b0;
      respWriteWay   <= 1'b0;
      respBypass     <= 1'b0;
    end else begin
      respValid      <= reqValid;
      respHit        <= active && anyHit;
      respHitWay     <= active ? hitWay : 2'h0;
      respToBus      <= toBus;
      respToL1       <= toL1;
      respArrayWrite <= wrEn;
      respWriteWay   <= wrWay;
      respBypass     <= bypass;
    end
  end

  // A machine check pulse for each enabled locked-line snoop invalidation
  always_ff @(posedge clk) begin
    if (reset) begin
      machineCheck <= 1'b0;
    end else begin
      machineCheck <= lockedSnoopHit && errEnable_reg;  // RQ2
    end
  end

  assign cacheEnabled = enable_reg;
  assign wayLockField = lock_reg;

endmodule : l2_cache_lock_and_invalidate

// ### rtl/l2_lock_pkg.sv
// Constants, field layout and types for the second-level cache lock/invalidate control
//
// Summary of operation
// RQ1: Lock field: 00 none, 01 way1, 10 way0, 11 both
// RQ2: Enabled snoop hit on locked line raises machine check
// RQ3: Locked-line snoop error flag sticky until software write
// RQ4: Read-only busy flag high during global invalidation
// RQ5: Cache comes up disabled after any reset
// RQ6: Sequencer clears every tag entry in turn
// RQ7: Invalidate bit starts sequencer; about 32K cycles
// RQ8: Software disables cache with barriers before invalidating
// RQ9: Software clears invalidate bit, then enables cache
// RQ10: No invalidation under power management; tight poll loop
// RQ11: Two ways, 4096 sets, two 32-byte sectors each
// RQ12: Locked lines never replaced nor newly allocated
// RQ13: Locked ways snooped exactly like unlocked ways
// RQ14: One way locked: fill unlocked way only
// RQ15: Both locked: reloads and castouts bypass cache
// RQ16: Write-through store hit in locked way updates, forwards
// RQ17: Inhibited/write-through conditional store hit invalidates, forwards
// RQ18: Flush/store-block hit: write castout if first-level hit
// RQ19: Block-zero leaves cache state unchanged
// RQ20: Block-invalidate hit invalidates in any way
// RQ21: Software fills way 0 with way 1 locked first
// RQ22: Start-up: disable, invalidate, configure, then enable
// RQ23: Enable bit 0 gates operation from next transaction
// RQ24: Data-only bit bypasses instruction requests without lookup
// RQ25: Busy flag set next cycle; retrigger ignored while busy
package l2_lock_pkg;

  // ---------------------------------------------------------------
  // Control register bit positions (bit 0 is the most significant)
  // ---------------------------------------------------------------
  localparam int CTRL_W          = 32;
  localparam int BIT_ENABLE      = 31 - 0;
  localparam int BIT_DATA_ONLY   = 31 - 9;
  localparam int BIT_GLOBAL_INV  = 31 - 10;
  localparam int BIT_LOCK_WAY0   = 31 - 20;
  localparam int BIT_LOCK_WAY1   = 31 - 21;
  localparam int BIT_SNOOP_ERREN = 31 - 22;
  localparam int BIT_SNOOP_ERR   = 31 - 23;
  localparam int BIT_INV_BUSY    = 31 - 31;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_STORED_MASK = 32'h8060_0E00;

  // ---------------------------------------------------------------
  // Way-lock encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_WAY1 = 2'h1;
  localparam logic [1:0] LOCK_WAY0 = 2'h2;
  localparam logic [1:0] LOCK_BOTH = 2'h3;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int NUM_SETS   = 4096;
  localparam int SET_W      = 12;
  localparam int TAG_W      = 14;
  localparam int SECTORS    = 2;
  localparam int SECTOR_B   = 32;
  // Nominal run length in core cycles, for reference only
  localparam int INV_CYCLES_NOMINAL = 32768;
  localparam int INV_CYCLES_PER_SET = 8;

  // ---------------------------------------------------------------
  // Request kinds
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    REQ_RELOAD   = 4'h0,
    REQ_CASTOUT  = 4'h1,
    REQ_STORE_WT = 4'h2,
    REQ_STCX     = 4'h3,
    REQ_FLUSH    = 4'h4,
    REQ_ZERO     = 4'h5,
    REQ_INVBLK   = 4'h6,
    REQ_SNOOP    = 4'h7,
    REQ_READ     = 4'h8
  } req_kind_e;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_CLEAR = 3'b010,
    SEQ_DONE  = 3'b100
  } seq_state_e;

endpackage : l2_lock_pkg

// ### rtl/l2_inv_sequencer.sv
// Global tag invalidation sequencer: walks every set and clears both ways
module l2_inv_sequencer
  import l2_lock_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             start,
  output logic                  busy,
  // Tag clear port
  output logic                  clrValid,
  output logic [SET_W-1:0]      clrSet
);

  seq_state_e     state_reg;
  logic [2:0]     pace_reg;
  logic [SET_W-1:0] set_reg;

  // Each set gets several cycles so the full walk lands near the nominal length
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SEQ_IDLE;
      pace_reg  <= 3'h0;
      set_reg   <= '0;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          if (start) begin                          // RQ25
            state_reg <= SEQ_CLEAR;                 // RQ7
            pace_reg  <= 3'h0;
            set_reg   <= '0;
          end
        end
        SEQ_CLEAR: begin
          pace_reg <= pace_reg + 3'h1;
          if (pace_reg == 3'(INV_CYCLES_PER_SET - 1)) begin
            set_reg <= set_reg + 1'b1;              // RQ6
            if (set_reg == SET_W'(NUM_SETS - 1)) begin
              state_reg <= SEQ_DONE;
            end
          end
        end
        SEQ_DONE: begin
          state_reg <= SEQ_IDLE;
        end
        default: begin
          state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    busy     = (state_reg != SEQ_IDLE);             // RQ4
    clrValid = (state_reg == SEQ_CLEAR) && (pace_reg == 3'h0);
    clrSet   = set_reg;
  end

endmodule : l2_inv_sequencer

// ### rtl/l2_tag_array.sv
// Two-way tag store with valid bits and one replacement bit per set
module l2_tag_array
  import l2_lock_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Lookup
  input  wire logic [SET_W-1:0] rdSet,
  input  wire logic [TAG_W-1:0] rdTag,
  output logic [1:0]            hitWay,
  output logic                  lruWay,
  // Update
  input  wire logic             wrEn,
  input  wire logic [SET_W-1:0] wrSet,
  input  wire logic             wrWay,
  input  wire logic [TAG_W-1:0] wrTag,
  input  wire logic             wrValid,
  input  wire logic             lruEn,
  input  wire logic             lruVal,
  // Global clear
  input  wire logic             clrEn,
  input  wire logic [SET_W-1:0] clrSet
);

  logic [TAG_W-1:0] tagMem [2][NUM_SETS];
  logic             valMem [2][NUM_SETS];
  logic             lruMem [NUM_SETS];

  genvar w;
  generate
    for (w = 0; w < 2; w++) begin : g_way
      always_ff @(posedge clk) begin
        if (clrEn) begin
          tagMem[w][clrSet] <= '0;                  // RQ6
          valMem[w][clrSet] <= 1'b0;
        end else if (wrEn && (wrWay == 1'(w))) begin
          tagMem[w][wrSet] <= wrTag;
          valMem[w][wrSet] <= wrValid;
        end
      end
      assign hitWay[w] = valMem[w][rdSet] && (tagMem[w][rdSet] == rdTag);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (clrEn) begin
      lruMem[clrSet] <= 1'b0;                       // RQ6
    end else if (lruEn) begin
      lruMem[wrSet] <= lruVal;
    end
  end

  assign lruWay = lruMem[rdSet];

endmodule : l2_tag_array

// ### bench/l2_cache_lock_checker.sv
// Port-level assertions for the second-level cache lock and invalidate block
module l2_cache_lock_checker
  import l2_lock_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register and request side
  input wire logic        ctrlWrite,
  input wire logic [31:0] ctrlWrData,
  input wire logic [31:0] ctrlRdData,
  input wire logic        reqValid,
  input wire logic [3:0]  reqKind,
  input wire logic        reqFromInstr,
  // Results
  input wire logic        respHit,
  input wire logic        respArrayWrite,
  input wire logic        respWriteWay,
  input wire logic        respBypass,
  input wire logic        cacheEnabled,
  input wire logic [1:0]  wayLockField,
  input wire logic        machineCheck
);
  localparam int INV_LEN = NUM_SETS * INV_CYCLES_PER_SET + 1;
  int          busyCnt;
  logic [31:0] wrPrev;
  logic [1:0]  lockPrev;
  logic        allocPrev;
  wire logic   busy = ctrlRdData[BIT_INV_BUSY];

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Busy length counted here, far too long for a repetition
  always_ff @(posedge clk) begin
    if (reset || !busy) busyCnt <= 0;
    else busyCnt <= busyCnt + 1;
  end
  always_ff @(posedge clk) begin
    wrPrev   <= ctrlWrData;
    lockPrev <= wayLockField;
  end
  always_ff @(posedge clk) begin
    if (reset) allocPrev <= 1'b0;
    else allocPrev <= reqValid && (reqKind == REQ_RELOAD || reqKind == REQ_CASTOUT);
  end

  sequence s_inv_start;
    ctrlWrite && ctrlWrData[BIT_GLOBAL_INV] && !ctrlRdData[BIT_GLOBAL_INV] && !busy;
  endsequence
  sequence s_inv_hold;
    busy [*8];
  endsequence
  property p_inv_start; s_inv_start |=> s_inv_hold; endproperty
  a_inv_start: assert property (p_inv_start) else $error("busy did not rise");
  property p_inv_len; $fell(busy) |-> busyCnt == INV_LEN; endproperty
  a_inv_len: assert property (p_inv_len) else $error("invalidate length wrong");
  property p_lock_copy;
    ctrlWrite |=> wayLockField == {wrPrev[BIT_LOCK_WAY0], wrPrev[BIT_LOCK_WAY1]};
  endproperty
  a_lock_copy: assert property (p_lock_copy) else $error("lock field wrong");
  property p_enable_copy; ctrlWrite |=> cacheEnabled == wrPrev[BIT_ENABLE]; endproperty
  a_enable_copy: assert property (p_enable_copy) else $error("enable wrong");
  property p_refuse;
    reqValid && (busy || (!cacheEnabled && reqKind != REQ_SNOOP))
      |=> respBypass && !respArrayWrite;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request not refused");
  property p_mc_cause;
    machineCheck |-> $past(reqValid) && respHit && respArrayWrite
      && ctrlRdData[BIT_SNOOP_ERREN] && ctrlRdData[BIT_SNOOP_ERR];
  endproperty
  a_mc_cause: assert property (p_mc_cause) else $error("stray machine check");
  property p_flag_sticky;
    ctrlRdData[BIT_SNOOP_ERR] && !ctrlWrite |=> ctrlRdData[BIT_SNOOP_ERR];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("error flag lost");
  property p_no_alloc;
    allocPrev && respArrayWrite && !respHit |-> !(respWriteWay ? lockPrev[0] : lockPrev[1]);
  endproperty
  a_no_alloc: assert property (p_no_alloc) else $error("locked way filled");
  property p_both; allocPrev && lockPrev == LOCK_BOTH && !respHit |-> !respArrayWrite; endproperty
  a_both: assert property (p_both) else $error("array written with both locked");
  property p_zero; reqValid && reqKind == REQ_ZERO |=> !respArrayWrite; endproperty
  a_zero: assert property (p_zero) else $error("block zero wrote array");
  property p_data_only;
    reqValid && reqFromInstr && ctrlRdData[BIT_DATA_ONLY] |=> respBypass && !respHit;
  endproperty
  a_data_only: assert property (p_data_only) else $error("instr not bypassed");
endmodule : l2_cache_lock_checker

bind l2_cache_lock_and_invalidate l2_cache_lock_checker u_checker (
  .clk(clk), .reset(reset), .ctrlWrite(ctrlWrite), .ctrlWrData(ctrlWrData),
  .ctrlRdData(ctrlRdData), .reqValid(reqValid), .reqKind(reqKind),
  .reqFromInstr(reqFromInstr), .respHit(respHit), .respArrayWrite(respArrayWrite),
  .respWriteWay(respWriteWay), .respBypass(respBypass), .cacheEnabled(cacheEnabled),
  .wayLockField(wayLockField), .machineCheck(machineCheck)
);

// ### bench/l2_core_model.sv
// Core and first-level cache side: issues one request at a time
module l2_core_model
  import l2_lock_pkg::*;
(
  input  wire logic        clk,
  output logic             reqValid,
  output logic [3:0]       reqKind,
  output logic [SET_W-1:0] reqSet,
  output logic [TAG_W-1:0] reqTag,
  output logic             reqFromInstr,
  output logic             reqInhibited,
  output logic             reqWriteThru,
  output logic             reqL1Hit
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reqValid = 1'b0;
    reqKind = 4'h0;
    reqSet = '0;
    reqTag = '0;
    {reqFromInstr, reqInhibited, reqWriteThru, reqL1Hit} = 4'h0;
  end

  // Attribute order: instr, inhibited, write-through, first-level hit
  task automatic issue(input logic [3:0] kind, input logic [SET_W-1:0] set,
                       input logic [TAG_W-1:0] tag, input logic [3:0] attr);
    @(posedge clk);
    reqValid <= 1'b1;
    reqKind  <= kind;
    reqSet   <= set;
    reqTag   <= tag;
    {reqFromInstr, reqInhibited, reqWriteThru, reqL1Hit} <= attr;
    @(posedge clk);
    reqValid <= 1'b0;
    // Idle lines carry the inverse so a stale value cannot pass for a match
    reqSet   <= ~set;
    reqTag   <= ~tag;
  endtask : issue
endmodule : l2_core_model

// ### bench/l2_cache_lock_and_invalidate_tb_top.sv
// Self-checking testbench for the second-level cache lock and invalidate block
module l2_cache_lock_and_invalidate_tb_top
  import l2_lock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic             clk = 1'b0;
  logic             reset = 1'b1;
  logic             ctrlWrite = 1'b0;
  logic [31:0]      ctrlWrData = 32'h0000_0000;
  logic [31:0]      ctrlRdData;
  logic             reqValid, reqFromInstr, reqInhibited, reqWriteThru, reqL1Hit;
  logic [3:0]       reqKind;
  logic [SET_W-1:0] reqSet;
  logic [TAG_W-1:0] reqTag;
  logic             respValid, respHit, respToBus, respToL1;
  logic             respArrayWrite, respWriteWay, respBypass;
  logic [1:0]       respHitWay, wayLockField;
  logic             cacheEnabled, machineCheck;
  logic [5:0]       respVec;
  int               fails = 0;
  int               totalChecks = 0;

  assign respVec = {respHit, respArrayWrite, respWriteWay, respToBus, respToL1, respBypass};
  always #25 clk = ~clk;

  l2_cache_lock_and_invalidate u_dut (
    .clk(clk), .reset(reset), .ctrlWrite(ctrlWrite), .ctrlWrData(ctrlWrData),
    .ctrlRdData(ctrlRdData), .reqValid(reqValid), .reqKind(reqKind), .reqSet(reqSet),
    .reqTag(reqTag), .reqFromInstr(reqFromInstr), .reqInhibited(reqInhibited),
    .reqWriteThru(reqWriteThru), .reqL1Hit(reqL1Hit), .respValid(respValid),
    .respHit(respHit), .respHitWay(respHitWay), .respToBus(respToBus),
    .respToL1(respToL1), .respArrayWrite(respArrayWrite), .respWriteWay(respWriteWay),
    .respBypass(respBypass), .cacheEnabled(cacheEnabled), .wayLockField(wayLockField),
    .machineCheck(machineCheck));

  l2_core_model u_core (
    .clk(clk), .reqValid(reqValid), .reqKind(reqKind), .reqSet(reqSet), .reqTag(reqTag),
    .reqFromInstr(reqFromInstr), .reqInhibited(reqInhibited),
    .reqWriteThru(reqWriteThru), .reqL1Hit(reqL1Hit));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] cfg(input logic en, input logic [1:0] lock,
                                      input logic errEn, input logic dOnly, input logic inv);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[BIT_ENABLE] = en;
    v[BIT_LOCK_WAY0] = lock[1];
    v[BIT_LOCK_WAY1] = lock[0];
    v[BIT_SNOOP_ERREN] = errEn;
    v[BIT_DATA_ONLY] = dOnly;
    v[BIT_GLOBAL_INV] = inv;
    return v;
  endfunction : cfg

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [31:0] d);
    @(posedge clk);
    ctrlWrite  <= 1'b1;
    ctrlWrData <= d;
    @(posedge clk);
    ctrlWrite <= 1'b0;
    #1;
  endtask : wr

  // Response fields: hit, array write, write way, to bus, to L1, bypass
  task automatic req(input logic [3:0] kind, input logic [SET_W-1:0] set,
                     input logic [TAG_W-1:0] tag, input logic [3:0] attr,
                     input logic [5:0] mask, input logic [5:0] exp);
    u_core.issue(kind, set, tag, attr);
    #1;
    check(respVec & mask, exp);
  endtask : req

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic testReset;
    #1;
    check(ctrlRdData, CTRL_RESET);
    check({cacheEnabled, wayLockField, machineCheck}, 4'h0);
    req(REQ_RELOAD, 12'h005, 14'h0003, 4'h0, 6'h15, 6'h05);
    check(respValid, 1'b1);
  endtask : testReset

  task automatic testInvalidate;
    int n;
    wr(cfg(1'b0, LOCK_NONE, 1'b0, 1'b0, 1'b1));
    check(ctrlRdData[BIT_INV_BUSY], 1'b1);
    n = 0;
    // No requests while polling; a restart mid-run must be ignored
    while (ctrlRdData[BIT_INV_BUSY] === 1'b1 && n < 40000) begin
      @(posedge clk);
      ctrlWrite  <= (n == 50 || n == 100);
      ctrlWrData <= (n == 100) ? cfg(1'b0, LOCK_NONE, 1'b0, 1'b0, 1'b1) : CTRL_RESET;
      n++;
      #1;
    end
    check(n, NUM_SETS * INV_CYCLES_PER_SET + 1);
    check(ctrlRdData[BIT_INV_BUSY], 1'b0);
    wr(CTRL_RESET);
    wr(cfg(1'b1, LOCK_WAY1, 1'b0, 1'b1, 1'b0));
    check(ctrlRdData, cfg(1'b1, LOCK_WAY1, 1'b0, 1'b1, 1'b0));
    check(wayLockField, LOCK_WAY1);
  endtask : testInvalidate

  task automatic testOneWayLocked;
    req(REQ_RELOAD, 12'h005, 14'h0003, 4'h0, 6'h38, 6'h10);
    req(REQ_RELOAD, 12'h005, 14'h0004, 4'h0, 6'h38, 6'h10);
    req(REQ_RELOAD, 12'h005, 14'h0004, 4'h0, 6'h20, 6'h20);
    check(respHitWay, 2'h1);
    req(REQ_RELOAD, 12'h005, 14'h0003, 4'h0, 6'h38, 6'h10);
    req(REQ_RELOAD, 12'hFFF, 14'h0001, 4'h0, 6'h38, 6'h10);
  endtask : testOneWayLocked

  task automatic testSnoopLocked;
    wr(cfg(1'b1, LOCK_WAY0, 1'b1, 1'b0, 1'b0));
    check(wayLockField, LOCK_WAY0);
    req(REQ_STORE_WT, 12'h005, 14'h0003, 4'h2, 6'h34, 6'h34);
    req(REQ_SNOOP, 12'h005, 14'h0003, 4'h0, 6'h30, 6'h30);
    check(machineCheck, 1'b1);
    req(REQ_RELOAD, 12'h005, 14'h0009, 4'h0, 6'h38, 6'h18);
    check(ctrlRdData[BIT_SNOOP_ERR], 1'b1);
    wr(cfg(1'b1, LOCK_WAY0, 1'b1, 1'b0, 1'b0));
    check(ctrlRdData[BIT_SNOOP_ERR], 1'b0);
    req(REQ_FLUSH, 12'hFFF, 14'h0001, 4'h1, 6'h34, 6'h30);
    req(REQ_INVBLK, 12'hFFF, 14'h0001, 4'h0, 6'h30, 6'h30);
    req(REQ_READ, 12'hFFF, 14'h0001, 4'h0, 6'h20, 6'h00);
  endtask : testSnoopLocked

  task automatic testBothLocked;
    wr(cfg(1'b1, LOCK_BOTH, 1'b0, 1'b1, 1'b0));
    req(REQ_RELOAD, 12'h009, 14'h0007, 4'h0, 6'h32, 6'h02);
    req(REQ_CASTOUT, 12'h009, 14'h0007, 4'h0, 6'h34, 6'h04);
    req(REQ_ZERO, 12'h005, 14'h0009, 4'h0, 6'h10, 6'h00);
    req(REQ_RELOAD, 12'h005, 14'h0009, 4'h8, 6'h31, 6'h01);
    wr(CTRL_RESET);
    req(REQ_RELOAD, 12'h005, 14'h0009, 4'h0, 6'h15, 6'h05);
  endtask : testBothLocked

  task automatic endOfTest;
    $display("checks=%0d fails=%0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : endOfTest

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    testReset();
    testInvalidate();
    testOneWayLocked();
    testSnoopLocked();
    testBothLocked();
    endOfTest();
  end

  // Invalidation alone takes about 33K cycles
  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    endOfTest();
  end
endmodule : l2_cache_lock_and_invalidate_tb_top
